// ===== include/fgrt_cfg_if.sv
`default_nettype none
// ============================================================
// Trap state handed from the register file to the decision logic.
interface fgrt_cfg_if;
  logic [63:0] ctrl;
  logic        hyp_impl;
  logic        hyp_en;
  logic        mon_impl;
  logic        mon_fgt;
  logic        host_mode;
  logic        trap_gen;
  modport regs (output ctrl, hyp_impl, hyp_en, mon_impl, mon_fgt, host_mode, trap_gen);
  modport dec  (input  ctrl, hyp_impl, hyp_en, mon_impl, mon_fgt, host_mode, trap_gen);
endinterface : fgrt_cfg_if
`default_nettype wire

// ===== include/fgrt_map.svh
`ifndef FGRT_MAP_SVH
`define FGRT_MAP_SVH
// ============================================================
// Register map and field positions.
`define FGRT_ADDR_CTRL_LO   4'h0
`define FGRT_ADDR_CTRL_HI   4'h4
`define FGRT_ADDR_CONFIG    4'h8
`define FGRT_ADDR_STATUS    4'hC
`define FGRT_BIT_TP2        55
`define FGRT_BIT_SPRI       54
`define FGRT_BIT_ACCD       50
`define FGRT_BIT_ERADDR     49
`define FGRT_BIT_PFCDN      48
`define FGRT_BIT_PFCTL      47
`define FGRT_BIT_PFFEAT     46
`define FGRT_BIT_ERMISC     45
`define FGRT_BIT_ERSTAT     44
`define FGRT_BIT_ERCTL      43
`define FGRT_BIT_ERFEAT     42
`define FGRT_BIT_ERSEL      41
`define FGRT_BIT_ERIDENT    40
`define FGRT_SYNDROME_CLASS 6'h18
`define FGRT_RESET_HI       32'h0000_0000
`define FGRT_CFG_HYP_IMPL   0
`define FGRT_CFG_HYP_EN     1
`define FGRT_CFG_MON_IMPL   2
`define FGRT_CFG_MON_FGT    3
`define FGRT_CFG_HOST_MODE  4
`define FGRT_CFG_TRAP_GEN   5
`endif

// ===== include/fgrt_pkg.sv
`default_nettype none
// ============================================================
// Types shared by the trap unit.
package fgrt_pkg;
  typedef enum logic [3:0] {
    LVL_USER   = 4'h1,
    LVL_KERNEL = 4'h2,
    LVL_HYP    = 4'h4,
    LVL_MON    = 4'h8
  } level_e;
  typedef enum logic [3:0] {
    SR_TP2    = 4'h0,
    SR_SPRI   = 4'h1,
    SR_ACCD   = 4'h2,
    SR_ERADDR = 4'h3,
    SR_PFCDN  = 4'h4,
    SR_PFCTL  = 4'h5,
    SR_PFFEAT = 4'h6,
    SR_ERMISC = 4'h7,
    SR_ERSTAT = 4'h8,
    SR_ERCTL  = 4'h9,
    SR_ERFEAT = 4'hA,
    SR_ERSEL  = 4'hB,
    SR_ERID   = 4'hC,
    SR_OTHER  = 4'hF
  } sysreg_e;
endpackage : fgrt_pkg
`default_nettype wire

// ===== logic/fgrt_decide.sv
`include "fgrt_map.svh"
`default_nettype none
// ============================================================
// Combinational trap decision for one read request.
module fgrt_decide (
  fgrt_cfg_if.dec               cfg,
  input  wire fgrt_pkg::level_e  level_i,
  input  wire fgrt_pkg::sysreg_e reg_i,
  input  wire logic              higher_exc_i,
  output logic                   trap_o
);
  import fgrt_pkg::*;
  logic gate;
  logic sel;
  logic kern;
  always_comb begin
    kern = (level_i == LVL_KERNEL);
    gate = cfg.hyp_impl && cfg.hyp_en && (!cfg.mon_impl || cfg.mon_fgt); // [RQ3]
    unique case (reg_i)
      SR_TP2:    sel = !cfg.ctrl[`FGRT_BIT_TP2] && (kern || level_i == LVL_USER)
                       && !(cfg.host_mode && cfg.trap_gen); // [RQ5]
      SR_SPRI:   sel = kern && !cfg.ctrl[`FGRT_BIT_SPRI]; // [RQ6]
      SR_ACCD:   sel = kern && !cfg.ctrl[`FGRT_BIT_ACCD]; // [RQ7]
      SR_ERADDR: sel = kern && cfg.ctrl[`FGRT_BIT_ERADDR]; // [RQ9]
      SR_PFCDN:  sel = kern && cfg.ctrl[`FGRT_BIT_PFCDN]; // [RQ10]
      SR_PFCTL:  sel = kern && cfg.ctrl[`FGRT_BIT_PFCTL]; // [RQ11]
      SR_PFFEAT: sel = kern && cfg.ctrl[`FGRT_BIT_PFFEAT]; // [RQ12]
      SR_ERMISC: sel = kern && cfg.ctrl[`FGRT_BIT_ERMISC]; // [RQ13]
      SR_ERSTAT: sel = kern && cfg.ctrl[`FGRT_BIT_ERSTAT]; // [RQ14]
      SR_ERCTL:  sel = kern && cfg.ctrl[`FGRT_BIT_ERCTL]; // [RQ15]
      SR_ERFEAT: sel = kern && cfg.ctrl[`FGRT_BIT_ERFEAT]; // [RQ16]
      SR_ERSEL:  sel = kern && cfg.ctrl[`FGRT_BIT_ERSEL]; // [RQ17]
      SR_ERID:   sel = kern && cfg.ctrl[`FGRT_BIT_ERIDENT]; // [RQ18]
      default:   sel = 1'b0;
    endcase
    trap_o = gate && sel && !higher_exc_i; // [RQ4]
  end
endmodule : fgrt_decide
`default_nettype wire

// ===== logic/fine_grained_read_trap.sv
`include "fgrt_map.svh"
`default_nettype none
// ============================================================
// Fine-grained read trap: control register, Wishbone slave and decision.
// Overview of operation
// RQ1: Register exists only with fine-trap feature; without it trap_o stays low but trap_class_o still reports 0x18.
// RQ2: Register is 64 bits, fixed positions.
// RQ3: Trap needs hypervisor enabled and monitor gate.
// RQ4: Trap reports class 0x18; higher exception wins.
// RQ5: Bit 55 low traps thread-pointer-2 reads.
// RQ6: Bit 54 low traps streaming-priority reads.
// RQ7: Bit 50 low traps accelerator-data reads.
// RQ8: Active-low bits reset to zero always.
// RQ9: Bit 49 high traps error address reads.
// RQ10: Bit 48 high traps countdown reads.
// RQ11: Bit 47 high traps pseudo-fault control reads.
// RQ12: Bit 46 high traps pseudo-fault feature reads.
// RQ13: Bit 45 traps misc registers zero-three.
// RQ14: Bit 44 high traps error status reads.
// RQ15: Bit 43 high traps error control reads.
// RQ16: Bit 42 high traps error feature reads.
// RQ17: Bit 41 high traps record select reads.
// RQ18: Bit 40 high traps record ident reads.
// RQ19: Error bits reserved-zero when no records.
// RQ20: Error bits reset zero without monitor level.
// RQ21: Reserved and unsupported bits read zero.
module fine_grained_read_trap #(
  parameter bit         FINE_TRAP_FEATURE  = 1'b1,
  parameter bit         MATRIX_FEATURE     = 1'b1,
  parameter bit         ACCEL_STORE_FEATURE = 1'b1,
  parameter bit         RELIABILITY_FEATURE = 1'b1,
  parameter bit         RELIABILITY_V11    = 1'b1,
  parameter bit         MONITOR_IMPL       = 1'b1,
  parameter bit         ERR_REGS_ABSENT    = 1'b0,
  parameter logic [15:0] RECORD_COUNT      = 16'h0001,
  parameter logic [31:0] UNKNOWN_RESET_HI  = 32'h0000_0000
) (
  input  wire  logic              clk_i,
  input  wire  logic              rst_i,
  input  wire  logic              cyc_i,
  input  wire  logic              stb_i,
  input  wire  logic              we_i,
  input  wire  logic [3:0]        adr_i,
  input  wire  logic [3:0]        sel_i,
  input  wire  logic [31:0]       dat_i,
  output logic [31:0]             dat_o,
  output logic                    ack_o,
  output logic                    err_o,
  input  wire  logic              req_valid_i,
  input  wire  fgrt_pkg::level_e  req_level_i,
  input  wire  fgrt_pkg::sysreg_e req_reg_i,
  input  wire  logic              req_higher_exc_i,
  output logic                    trap_o,
  output logic [5:0]              trap_class_o,
  output fgrt_pkg::sysreg_e       trap_reg_o
);
  import fgrt_pkg::*;

  // ============================================================
  // Which control bits are implemented.
  localparam logic ERR_AVAIL = RELIABILITY_FEATURE
                               && !(ERR_REGS_ABSENT && RECORD_COUNT == 16'h0000); // [RQ19]
  localparam logic [31:0] BIT_MASK_HI =
      ({31'h0, MATRIX_FEATURE}      << (`FGRT_BIT_TP2 - 32))
    | ({31'h0, MATRIX_FEATURE}      << (`FGRT_BIT_SPRI - 32))
    | ({31'h0, ACCEL_STORE_FEATURE} << (`FGRT_BIT_ACCD - 32))
    | ({31'h0, ERR_AVAIL}           << (`FGRT_BIT_ERADDR - 32))
    | ({31'h0, ERR_AVAIL && RELIABILITY_V11} << (`FGRT_BIT_PFCDN - 32))
    | ({31'h0, ERR_AVAIL && RELIABILITY_V11} << (`FGRT_BIT_PFCTL - 32))
    | ({31'h0, ERR_AVAIL} << (`FGRT_BIT_PFFEAT - 32))
    | ({31'h0, ERR_AVAIL} << (`FGRT_BIT_ERMISC - 32))
    | ({31'h0, ERR_AVAIL} << (`FGRT_BIT_ERSTAT - 32))
    | ({31'h0, ERR_AVAIL} << (`FGRT_BIT_ERCTL - 32))
    | ({31'h0, ERR_AVAIL} << (`FGRT_BIT_ERFEAT - 32))
    | ({31'h0, ERR_AVAIL} << (`FGRT_BIT_ERSEL - 32))
    | ({31'h0, ERR_AVAIL} << (`FGRT_BIT_ERIDENT - 32)); // [RQ21]
  localparam logic [31:0] ERR_FIELD_HI = 32'h0003_FF00;
  // Error-record bits take the unknown value only when a monitor level exists.
  localparam logic [31:0] RESET_HI = MONITOR_IMPL ?
      ((`FGRT_RESET_HI & ~ERR_FIELD_HI) | (UNKNOWN_RESET_HI & ERR_FIELD_HI) | 32'h0)
    : `FGRT_RESET_HI; // [RQ20]

  // ============================================================
  // Register state.
  logic [31:0] ctrl_hi_r;
  logic [5:0]  cfg_r;
  logic [31:0] trap_count_r;
  logic        ack_r;
  logic        err_r;
  logic [31:0] dat_r;
  logic        trap_r;
  logic [5:0]  class_r;
  sysreg_e     treg_r;
  logic        hit;
  logic        wr;
  logic        rd;
  logic        valid_adr;
  logic [31:0] wmask;
  logic        trap_now;
  logic [31:0] rdata;

  fgrt_cfg_if cfg_bus ();

  assign hit       = cyc_i && stb_i && !ack_r && !err_r;
  assign valid_adr = FINE_TRAP_FEATURE
                     || (adr_i != `FGRT_ADDR_CTRL_LO && adr_i != `FGRT_ADDR_CTRL_HI); // [RQ1]
  assign wr        = hit && we_i && valid_adr;
  assign rd        = hit && !we_i && valid_adr;
  assign wmask     = {{8{sel_i[3]}}, {8{sel_i[2]}}, {8{sel_i[1]}}, {8{sel_i[0]}}};

  // ============================================================
  // Control register; the low word is outside this unit and reads zero.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_hi_r <= RESET_HI & BIT_MASK_HI; // [RQ8]
    end else if (wr && adr_i == `FGRT_ADDR_CTRL_HI) begin
      ctrl_hi_r <= ((ctrl_hi_r & ~wmask) | (dat_i & wmask)) & BIT_MASK_HI; // [RQ21]
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cfg_r <= 6'h00;
    end else if (wr && adr_i == `FGRT_ADDR_CONFIG && sel_i[0]) begin
      cfg_r <= dat_i[5:0];
    end
  end

  assign cfg_bus.ctrl      = {ctrl_hi_r, 32'h0000_0000}; // [RQ2]
  assign cfg_bus.hyp_impl  = cfg_r[`FGRT_CFG_HYP_IMPL];
  assign cfg_bus.hyp_en    = cfg_r[`FGRT_CFG_HYP_EN];
  assign cfg_bus.mon_impl  = MONITOR_IMPL && cfg_r[`FGRT_CFG_MON_IMPL];
  assign cfg_bus.mon_fgt   = cfg_r[`FGRT_CFG_MON_FGT];
  assign cfg_bus.host_mode = cfg_r[`FGRT_CFG_HOST_MODE];
  assign cfg_bus.trap_gen  = cfg_r[`FGRT_CFG_TRAP_GEN];

  // ============================================================
  // Trap decision and reported syndrome.
  fgrt_decide u_decide (
    .cfg          (cfg_bus),
    .level_i      (req_level_i),
    .reg_i        (req_reg_i),
    .higher_exc_i (req_higher_exc_i),
    .trap_o       (trap_now)
  );

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      trap_r  <= 1'b0;
      class_r <= 6'h00;
      treg_r  <= SR_OTHER;
    end else begin
      trap_r  <= req_valid_i && trap_now && FINE_TRAP_FEATURE;
      class_r <= (req_valid_i && trap_now) ? `FGRT_SYNDROME_CLASS : 6'h00; // [RQ4]
      treg_r  <= req_valid_i ? req_reg_i : SR_OTHER;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      trap_count_r <= 32'h0000_0000;
    end else if (wr && adr_i == `FGRT_ADDR_STATUS) begin
      trap_count_r <= 32'h0000_0000;
    end else if (trap_r) begin
      trap_count_r <= trap_count_r + 32'h0000_0001;
    end
  end

  // ============================================================
  // Wishbone answer: one cycle after the request; unmapped gives err.
  always_comb begin
    unique case (adr_i)
      `FGRT_ADDR_CTRL_HI: rdata = ctrl_hi_r;
      `FGRT_ADDR_CONFIG:  rdata = {26'h0, cfg_r};
      `FGRT_ADDR_STATUS:  rdata = trap_count_r;
      default:            rdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
      err_r <= 1'b0;
      dat_r <= 32'h0000_0000;
    end else begin
      ack_r <= hit && valid_adr && adr_i[1:0] == 2'b00 && adr_i <= `FGRT_ADDR_STATUS;
      err_r <= hit && !(valid_adr && adr_i[1:0] == 2'b00); // [RQ1]
      dat_r <= rd ? rdata : 32'h0000_0000;
    end
  end

  assign ack_o        = ack_r;
  assign err_o        = err_r;
  assign dat_o        = dat_r;
  assign trap_o       = trap_r;
  assign trap_class_o = class_r;
  assign trap_reg_o   = treg_r;
endmodule : fine_grained_read_trap
`default_nettype wire

// ===== verification/fine_grained_read_trap_assertions.sv
`default_nettype none
// ================================================
// Port checks of the read-trap unit.
module fgrt_checker
  import fgrt_pkg::*;
(
  input wire logic              clk_i,
  input wire logic              rst_i,
  input wire logic              cyc_i,
  input wire logic              stb_i,
  input wire logic              ack_o,
  input wire logic              err_o,
  input wire logic [31:0]       dat_o,
  input wire logic              req_valid_i,
  input wire fgrt_pkg::level_e  req_level_i,
  input wire fgrt_pkg::sysreg_e req_reg_i,
  input wire logic              req_higher_exc_i,
  input wire logic              trap_o,
  input wire logic [5:0]        trap_class_o,
  input wire fgrt_pkg::sysreg_e trap_reg_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence bus_req_s;
    cyc_i && stb_i && !ack_o && !err_o;
  endsequence
  sequence req_s;
    req_valid_i;
  endsequence
  bus_answer_a: assert property (bus_req_s |=> ack_o ^ err_o)
    else $error("bus answer missing");
  ack_pulse_a: assert property (ack_o |=> !ack_o)
    else $error("ack too long");
  read_idle_a: assert property (!ack_o |-> dat_o == 32'h0)
    else $error("read data without ack");
  trap_class_a: assert property (trap_class_o == (trap_o ? 6'h18 : 6'h00))
    else $error("bad class");
  trap_reg_a: assert property (trap_o |-> trap_reg_o == $past(req_reg_i))
    else $error("bad trap register");
  higher_exc_a: assert property (req_s ##0 req_higher_exc_i |=> !trap_o)
    else $error("trap beat higher exception");
  no_request_a: assert property (!req_valid_i |=> !trap_o)
    else $error("trap without request");
  upper_level_a: assert property (req_s ##0 req_level_i inside {LVL_HYP, LVL_MON}
    |=> !trap_o) else $error("trap from upper level");
  user_scope_a: assert property (req_s ##0 req_level_i == LVL_USER
    && req_reg_i != SR_TP2 |=> !trap_o) else $error("user trap");
endmodule : fgrt_checker

bind fine_grained_read_trap fgrt_checker i_fgrt_checker (.clk_i, .rst_i, .cyc_i,
  .stb_i, .ack_o, .err_o, .dat_o, .req_valid_i, .req_level_i, .req_reg_i,
  .req_higher_exc_i, .trap_o, .trap_class_o, .trap_reg_o);
`default_nettype wire

// ===== verification/fine_grained_read_trap_tb_top.sv
`default_nettype none
// ================================================
// Bus and trap-request tests.
module fine_grained_read_trap_tb_top
  import fgrt_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc_i = 1'b0;
  logic        stb_i = 1'b0;
  logic        we_i = 1'b0;
  logic [3:0]  adr_i = 4'h0;
  logic [3:0]  sel_i = 4'h0;
  logic [31:0] dat_i = 32'h0;
  logic        req_valid_i = 1'b0;
  level_e      req_level_i = LVL_USER;
  sysreg_e     req_reg_i = SR_OTHER;
  logic        req_higher_exc_i = 1'b0;
  logic [31:0] dat_o;
  logic        ack_o, err_o, trap_o, er;
  logic [5:0]  trap_class_o;
  sysreg_e     trap_reg_o;
  logic [31:0] rd;
  int          fails = 0;
  int          n_compared = 0;
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin fails++; \
  $display("[ERR] %s exp %0h got %0h", nm, e, g); end end

  always #5 clk_i = ~clk_i;

  fine_grained_read_trap i_fine_grained_read_trap (.clk_i, .rst_i, .cyc_i, .stb_i,
    .we_i, .adr_i, .sel_i, .dat_i, .dat_o, .ack_o, .err_o, .req_valid_i,
    .req_level_i, .req_reg_i, .req_higher_exc_i, .trap_o, .trap_class_o, .trap_reg_o);

  task automatic wb(input logic w, input logic [3:0] a, input logic [3:0] s,
                    input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    {cyc_i, stb_i, we_i, adr_i, sel_i, dat_i} <= {2'b11, w, a, s, d};
    // The answer is sampled at the rising edge and the request released there.
    @(posedge clk_i);
    while (ack_o !== 1'b1 && err_o !== 1'b1 && n < 20) begin
      n++;
      @(posedge clk_i);
    end
    rd = dat_o;
    er = err_o;
    if (n == 20) fails++;
    {cyc_i, stb_i} <= 2'b00;
  endtask : wb

  task automatic rc(input logic [3:0] a, input logic [31:0] e, input string nm);
    wb(1'b0, a, 4'hF, 32'h0);
    `CHK(nm, e, rd)
  endtask : rc

  task automatic rq(input level_e l, input sysreg_e r, input logic h, input logic x);
    @(posedge clk_i);
    req_valid_i <= 1'b1;
    req_level_i <= l;
    req_reg_i <= r;
    req_higher_exc_i <= h;
    @(posedge clk_i);
    req_valid_i <= 1'b0;
    #1;
    `CHK("trap", x, trap_o)
    `CHK("class", x ? 6'h18 : 6'h00, trap_class_o)
    if (x) `CHK("trap_reg", r, trap_reg_o)
  endtask : rq

  task automatic kr(input logic [3:0] k, input logic x);
    rq(LVL_KERNEL, sysreg_e'(k), 1'b0, x);
  endtask : kr

  task automatic report_and_stop();
    if (fails == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : report_and_stop

  initial begin
    #50000;
    fails++;
    report_and_stop();
  end

  initial begin
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    rc(4'h4, 32'h0, "ctrl_hi");
    rc(4'h0, 32'h0, "ctrl_lo");
    wb(1'b0, 4'h2, 4'hF, 32'h0);
    `CHK("unmapped", 1'b1, er)
    kr(4'h1, 1'b0);
    wb(1'b1, 4'h8, 4'hF, 32'h3);
    rc(4'h8, 32'h3, "config");
    rq(LVL_USER, SR_TP2, 1'b0, 1'b1);
    rq(LVL_HYP, SR_TP2, 1'b0, 1'b0);
    kr(4'h1, 1'b1);
    kr(4'h2, 1'b1);
    kr(4'h8, 1'b0);
    wb(1'b1, 4'h4, 4'h2, 32'hFFFF_FFFF);
    rc(4'h4, 32'h0000_FF00, "lane");
    wb(1'b1, 4'h4, 4'hF, 32'hFFFF_FFFF);
    rc(4'h4, 32'h00C7_FF00, "ones");
    for (int k = 0; k < 3; k++) kr(k[3:0], 1'b0);
    for (int k = 3; k < 8; k++) kr(k[3:0], 1'b1);
    for (int k = 8; k < 13; k++) kr(k[3:0], 1'b1);
    kr(4'hF, 1'b0);
    rq(LVL_KERNEL, SR_ERADDR, 1'b1, 1'b0);
    wb(1'b1, 4'h4, 4'hF, 32'h0);
    kr(4'h3, 1'b0);
    wb(1'b1, 4'h8, 4'hF, 32'h33);
    rq(LVL_USER, SR_TP2, 1'b0, 1'b0);
    wb(1'b1, 4'h8, 4'hF, 32'h13);
    rq(LVL_USER, SR_TP2, 1'b0, 1'b1);
    wb(1'b1, 4'h8, 4'hF, 32'h07);
    kr(4'h2, 1'b0);
    wb(1'b1, 4'h8, 4'hF, 32'h0F);
    kr(4'h2, 1'b1);
    wb(1'b1, 4'h8, 4'hF, 32'h0D);
    kr(4'h2, 1'b0);
    rc(4'hC, 32'h0000_000F, "trap_count");
    wb(1'b1, 4'hC, 4'hF, 32'h0);
    rc(4'hC, 32'h0, "count_clear");
    wb(1'b1, 4'h4, 4'hF, 32'hFFFF_FFFF);
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    rc(4'h4, 32'h0, "rereset");
    report_and_stop();
  end
endmodule : fine_grained_read_trap_tb_top
`default_nettype wire
